// [include/itm_pkg.sv]
// Package for the transfer mode control block: register layout, reset values, timing
package itm_pkg;

    // Register map (byte addresses)
    localparam logic [11:0] ITM_MODE_OFFSET   = 12'h000;  // Transfer mode register
    localparam logic [11:0] ITM_CTRL_OFFSET   = 12'h004;  // Mode and frame control
    localparam logic [11:0] ITM_STATUS_OFFSET = 12'h008;  // Frame state readback

    // Field positions in the mode register
    localparam int ITM_BIT_ORDER_POS   = 7;
    localparam int ITM_WAIT_POS        = 6;
    localparam int ITM_RSVD_HI_POS     = 5;
    localparam int ITM_RSVD_LO_POS     = 4;
    localparam int ITM_GUARD_POS       = 3;
    localparam int ITM_COUNT_LSB       = 0;
    localparam int ITM_COUNT_MSB       = 2;

    // Field positions in the control register
    localparam int ITM_CTRL_I2C_POS    = 0;
    localparam int ITM_CTRL_MASTER_POS = 1;
    localparam int ITM_CTRL_START_POS  = 2;

    // Reset values
    localparam logic       ITM_BIT_ORDER_RST = 1'b0;
    localparam logic       ITM_WAIT_RST      = 1'b0;
    localparam logic [2:0] ITM_COUNT_RST     = 3'h0;
    localparam logic       ITM_I2C_RST       = 1'b1;
    localparam logic       ITM_MASTER_RST    = 1'b0;

    // Counts
    localparam logic [3:0] ITM_I2C_ZERO_BITS  = 4'h9;  // Eight data plus acknowledge
    localparam logic [3:0] ITM_SYNC_ZERO_BITS = 4'h8;  // Eight data bits
    localparam logic [1:0] ITM_WAIT_CLOCKS    = 2'h2;  // Extra low transfer clocks

    // Transfer clock half period
    localparam int          ITM_SYS_CLK_NS   = 50;
    localparam int          ITM_HALF_NS      = 200;
    localparam logic [7:0]  ITM_HALF_CYCLES  =
        8'((ITM_HALF_NS + ITM_SYS_CLK_NS - 1) / ITM_SYS_CLK_NS);

    // Serial engine states, Gray coded in the order listed
    typedef enum logic [2:0]
    {
        ITM_IDLE    = 3'b000,
        ITM_LOW     = 3'b001,
        ITM_HIGH    = 3'b011,
        ITM_WAIT    = 3'b010,
        ITM_DONE    = 3'b110
    } itm_state_t;

    // Settings handed to the shifter
    typedef struct packed
    {
        logic       lsb_first;
        logic       wait_req;
        logic [3:0] bits_left;
    } itm_shift_cfg_t;

endpackage : itm_pkg

// [verilog/itm_transfer_mode.sv]
// Transfer mode register with bit order, wait insertion and guarded bit counter
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////////////
module itm_transfer_mode
(
    input  wire logic                   SYS_CLK,
    input  wire logic                   RST,
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [11:0]            PADDR,
    input  wire logic [31:0]            PWDATA,
    output logic      [31:0]            PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    input  wire logic                   SCL_IN,
    output logic                        SCL_OUT,
    output logic                        SCL_OE,
    output itm_pkg::itm_shift_cfg_t     SHIFT_CFG,
    output logic                        BIT_STROBE
);
    import itm_pkg::*;

    //////////////////////////////////////////////////////////////////////////////////////
    // Registered state
    logic        bit_order_select;      // Mode bit 7
    logic        wait_option;           // Mode bit 6
    logic [2:0]  frame_bit_counter;     // Bits still to move
    logic        i2c_format;            // One for I2C, zero for sync serial
    logic        master_mode;           // One when this end drives SCL
    itm_state_t  state;                 // Serial engine state
    logic [7:0]  half_count;            // Half period timer
    logic [3:0]  bits_left;             // Bits in current frame
    logic [1:0]  wait_left;             // Remaining wait clocks
    logic        scl_drive_low;         // Pulls SCL low when set
    logic        scl_meta;              // First sync stage
    logic        scl_sync;              // Second sync stage
    logic        scl_prev;              // Previous synced level
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        strobe;
    logic        wait_flag;             // Inserted wait, kept in a flop for the port
    logic        next_bit_order_select;
    logic        next_wait_option;
    logic [2:0]  next_frame_bit_counter;
    logic        next_i2c_format;
    logic        next_master_mode;
    itm_state_t  next_state;
    logic [7:0]  next_half_count;
    logic [3:0]  next_bits_left;
    logic [1:0]  next_wait_left;
    logic        next_scl_drive_low;
    logic [31:0] next_rdata;
    logic        next_ready;
    logic        next_slverr;
    logic        next_strobe;
    logic        next_wait_flag;
    logic        acc;                   // Access phase seen
    logic        wr_mode;
    logic        wr_ctrl;
    logic        start_req;
    logic        wait_active;
    logic        scl_rise;
    logic        scl_fall;
    logic [7:0]  mode_view;
    //////////////////////////////////////////////////////////////////////////////////////
    // Decode; one wait state so PREADY comes from a flop
    always_comb
    begin
        acc         = PSEL && PENABLE && !ready;
        wr_mode     = acc && PWRITE && (PADDR == ITM_MODE_OFFSET);
        wr_ctrl     = acc && PWRITE && (PADDR == ITM_CTRL_OFFSET);
        start_req   = wr_ctrl && PWDATA[ITM_CTRL_START_POS] && (state == ITM_IDLE);
        // Wait only for a master in I2C format
        wait_active = wait_option && master_mode && i2c_format;
        scl_rise    = scl_sync && !scl_prev;
        scl_fall    = !scl_sync && scl_prev;
        mode_view   = 8'h00;
        mode_view[ITM_BIT_ORDER_POS]        = bit_order_select;
        mode_view[ITM_WAIT_POS]             = wait_option;
        mode_view[ITM_RSVD_HI_POS]          = 1'b1;
        mode_view[ITM_RSVD_LO_POS]          = 1'b1;
        mode_view[ITM_GUARD_POS]            = 1'b1;
        mode_view[ITM_COUNT_MSB:ITM_COUNT_LSB] = frame_bit_counter;
    end
    //////////////////////////////////////////////////////////////////////////////////////
    // Register file and bus answer
    always_comb
    begin
        next_bit_order_select = bit_order_select;
        next_wait_option      = wait_option;
        next_i2c_format       = i2c_format;
        next_master_mode      = master_mode;
        next_rdata            = 32'h00000000;   // Data stands only with PREADY
        next_ready            = acc;
        next_slverr           = 1'b0;
        if (wr_mode)
        begin
            // Reserved and guard positions are not stored
            next_bit_order_select = PWDATA[ITM_BIT_ORDER_POS];
            next_wait_option      = PWDATA[ITM_WAIT_POS];
        end
        if (wr_ctrl)
        begin
            next_i2c_format  = PWDATA[ITM_CTRL_I2C_POS];
            next_master_mode = PWDATA[ITM_CTRL_MASTER_POS];
        end
        if (acc)
            unique case (PADDR)
                ITM_MODE_OFFSET:   next_rdata = {24'h000000, mode_view};
                ITM_CTRL_OFFSET:   next_rdata = {29'h00000000, 1'b0, master_mode, i2c_format};
                ITM_STATUS_OFFSET: next_rdata = {25'h0000000, state, bits_left};
                default:
                begin
                    // Unmapped: zero data and an error answer
                    next_rdata  = 32'h00000000;
                    next_slverr = 1'b1;
                end
            endcase
    end
    //////////////////////////////////////////////////////////////////////////////////////
    // Frame engine: counts bits, inserts the master wait
    always_comb
    begin
        next_state             = state;
        next_half_count        = half_count;
        next_bits_left         = bits_left;
        next_wait_left         = wait_left;
        next_scl_drive_low     = scl_drive_low;
        next_frame_bit_counter = frame_bit_counter;
        next_strobe            = 1'b0;
        // Guarded counter load; software keeps it to idle, SCL low
        if (wr_mode && !PWDATA[ITM_GUARD_POS])
        begin
            next_frame_bit_counter = PWDATA[ITM_COUNT_MSB:ITM_COUNT_LSB];
        end
        unique case (state)
            ITM_IDLE:
            begin
                next_scl_drive_low = 1'b0;
                if (start_req)
                begin
                    // Zero means a full frame, else n+1 or n bits
                    if (frame_bit_counter == 3'h0)
                        next_bits_left = i2c_format ? ITM_I2C_ZERO_BITS : ITM_SYNC_ZERO_BITS;
                    else
                        next_bits_left = {1'b0, frame_bit_counter} + {3'h0, i2c_format};
                    next_state         = ITM_LOW;
                    next_half_count    = ITM_HALF_CYCLES;
                    next_scl_drive_low = master_mode;
                end
            end
            ITM_LOW:
            begin
                if (master_mode)
                begin
                    next_half_count = half_count - 8'h01;
                    if (half_count == 8'h01)
                    begin
                        next_scl_drive_low = 1'b0;
                        next_half_count    = ITM_HALF_CYCLES;
                        next_state         = ITM_HIGH;
                    end
                end
                else if (scl_rise)
                    next_state = ITM_HIGH;
            end
            ITM_HIGH:
            begin
                // Master waits for SCL really high, so a stretching slave holds us
                if ((master_mode && scl_sync && half_count == 8'h01) || (!master_mode && scl_fall))
                begin
                    next_strobe            = 1'b1;
                    next_bits_left         = bits_left - 4'h1;
                    next_frame_bit_counter = frame_bit_counter - 3'h1;
                    next_half_count        = ITM_HALF_CYCLES;
                    next_scl_drive_low     = master_mode;
                    if (bits_left == 4'h1)
                        next_state = ITM_DONE;
                    else if (bits_left == 4'h2 && i2c_format && wait_active)
                    begin
                        next_state     = ITM_WAIT;
                        next_wait_left = ITM_WAIT_CLOCKS;
                        next_half_count = {ITM_HALF_CYCLES[6:0], 1'b0}; // Whole transfer clock
                    end
                    else
                        next_state = ITM_LOW;
                end
                else if (master_mode && scl_sync)
                    next_half_count = half_count - 8'h01;
            end
            ITM_WAIT:
            begin
                // SCL held low one transfer clock per pass
                next_half_count = half_count - 8'h01;
                if (half_count == 8'h01)
                begin
                    next_half_count = {ITM_HALF_CYCLES[6:0], 1'b0};
                    next_wait_left  = wait_left - 2'h1;
                    if (wait_left == 2'h1)
                    begin
                        next_half_count = ITM_HALF_CYCLES;
                        next_state      = ITM_LOW;
                    end
                end
            end
            ITM_DONE:
            begin
                next_frame_bit_counter = 3'h0;
                next_scl_drive_low     = 1'b0;
                next_state             = ITM_IDLE;
            end
            default:
                next_state = ITM_IDLE;
        endcase
        // Registered so the port comes straight from a flop
        next_wait_flag = (next_state == ITM_WAIT);
    end
    //////////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            bit_order_select  <= ITM_BIT_ORDER_RST;
            wait_option       <= ITM_WAIT_RST;
            frame_bit_counter <= ITM_COUNT_RST;
            i2c_format        <= ITM_I2C_RST;
            master_mode       <= ITM_MASTER_RST;
            state             <= ITM_IDLE;
            half_count        <= 8'h00;
            bits_left         <= 4'h0;
            wait_left         <= 2'h0;
            scl_drive_low     <= 1'b0;
            scl_meta          <= 1'b1;
            scl_sync          <= 1'b1;
            scl_prev          <= 1'b1;
            rdata             <= 32'h00000000;
            ready             <= 1'b0;
            slverr            <= 1'b0;
            strobe            <= 1'b0;
            wait_flag         <= 1'b0;
        end
        else
        begin
            bit_order_select  <= next_bit_order_select;
            wait_option       <= next_wait_option;
            frame_bit_counter <= next_frame_bit_counter;
            i2c_format        <= next_i2c_format;
            master_mode       <= next_master_mode;
            state             <= next_state;
            half_count        <= next_half_count;
            bits_left         <= next_bits_left;
            wait_left         <= next_wait_left;
            scl_drive_low     <= next_scl_drive_low;
            scl_meta          <= SCL_IN;
            scl_sync          <= scl_meta;
            scl_prev          <= scl_sync;
            rdata             <= next_rdata;
            ready             <= next_ready;
            slverr            <= next_slverr;
            strobe            <= next_strobe;
            wait_flag         <= next_wait_flag;
        end
    end
    //////////////////////////////////////////////////////////////////////////////////////
    // Outputs from flops, except SCL_OUT which is tied low
    always_comb
    begin
        PRDATA              = rdata;
        PREADY              = ready;
        PSLVERR             = slverr;
        SCL_OUT             = 1'b0;
        SCL_OE              = scl_drive_low;
        SHIFT_CFG.lsb_first = bit_order_select;
        SHIFT_CFG.wait_req  = wait_flag;
        SHIFT_CFG.bits_left = bits_left;
        BIT_STROBE          = strobe;
    end
endmodule : itm_transfer_mode

// [testbench/itm_transfer_mode_asserts.sv]
// Checker for the transfer mode block ports, bound to the design
`timescale 1ns/1ps
module itm_transfer_mode_chk
(
    input wire logic                    SYS_CLK,
    input wire logic                    RST,
    input wire logic                    PSEL,
    input wire logic                    PENABLE,
    input wire logic                    PWRITE,
    input wire logic [11:0]             PADDR,
    input wire logic [31:0]             PWDATA,
    input wire logic [31:0]             PRDATA,
    input wire logic                    PREADY,
    input wire logic                    PSLVERR,
    input wire logic                    SCL_IN,
    input wire logic                    SCL_OUT,
    input wire logic                    SCL_OE,
    input wire itm_pkg::itm_shift_cfg_t SHIFT_CFG,
    input wire logic                    BIT_STROBE
);
    import itm_pkg::*;
    logic [4:0] wait_cnt;       // Run length of the inserted wait
    logic [4:0] next_wait_cnt;  // Next run length
    logic       mode_hit;       // Answer on the mode register
    logic       mapped;         // Address is a decoded register
    //////////////////////////////////////////////////////////////////////////////
    // Wait run counter; 5 bits so the expected run of 16 fits without wrapping
    always_comb next_wait_cnt = SHIFT_CFG.wait_req ? wait_cnt + 5'h01 : 5'h00;
    always_ff @(posedge SYS_CLK) wait_cnt <= RST ? 5'h00 : next_wait_cnt;
    assign mode_hit = PREADY && (PADDR == ITM_MODE_OFFSET);
    assign mapped = PADDR inside {ITM_MODE_OFFSET, ITM_CTRL_OFFSET, ITM_STATUS_OFFSET};
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    //////////////////////////////////////////////////////////////////////////////
    a_ready_one_wait: assert property (PSEL && PENABLE && !$past(PENABLE) |=> PREADY)
        else $error("ready not one cycle after access");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_idle_rdata_zero: assert property (!PREADY |-> PRDATA == 32'h00000000)
        else $error("read data outside an answer");
    a_rsvd_read_ones: assert property (mode_hit && !PWRITE |-> PRDATA[5:4] == 2'h3)
        else $error("reserved bits not read as ones");
    a_guard_read_one: assert property (mode_hit && !PWRITE |-> PRDATA[3])
        else $error("guard bit not read as one");
    a_order_follows: assert property (mode_hit && PWRITE |-> SHIFT_CFG.lsb_first == PWDATA[7])
        else $error("bit order not taken from write");
    a_guard_keeps: assert property (mode_hit && PWRITE && PWDATA[3] && !BIT_STROBE
        && !$past(BIT_STROBE) |-> $stable(SHIFT_CFG.bits_left))
        else $error("guarded write changed counter");
    a_unmapped_err: assert property (PREADY |-> PSLVERR == !mapped)
        else $error("error response wrong for address");
    a_wait_holds_low: assert property (SHIFT_CFG.wait_req && $past(SHIFT_CFG.wait_req)
        |-> SCL_OE)
        else $error("clock released during wait");
    a_wait_span: assert property ($fell(SHIFT_CFG.wait_req) |-> wait_cnt == 5'h10)
        else $error("wait not two transfer clocks");
    a_strobe_pulse: assert property (BIT_STROBE |=> !BIT_STROBE)
        else $error("bit strobe longer than one cycle");
    c_wait_seen: cover property ($rose(SHIFT_CFG.wait_req));
    c_unmapped: cover property (PREADY && PSLVERR);
    c_lsb_first: cover property ($rose(SHIFT_CFG.lsb_first));
endmodule : itm_transfer_mode_chk

bind itm_transfer_mode itm_transfer_mode_chk u_chk (.SYS_CLK(SYS_CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_IN(SCL_IN),
    .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SHIFT_CFG(SHIFT_CFG), .BIT_STROBE(BIT_STROBE));

// [testbench/itm_scl_peer.sv]
// Far side of the serial clock: pull-up wire and an external clock source
`timescale 1ns/1ps
module itm_scl_peer
(
    input  wire logic dev_pull,
    output logic      scl_wire
);
    logic peer_pull;  // Peer holds the wire low
    // Open-drain wire with pull-up: low while any party pulls
    assign scl_wire = !(dev_pull || peer_pull);
    initial peer_pull = 1'b0;
    // External clock at 400 ns; stretch lengthens each low phase for a slow peer
    // n high pulses framed by n+1 falls, so the last bit is closed by a fall too
    task automatic clocks(input int n, input int stretch_ns);
        int i;
        peer_pull = 1'b1;
        #(200 + stretch_ns);
        for (i = 0; i < n; i++)
        begin
            peer_pull = 1'b0;
            #200;
            peer_pull = 1'b1;
            #(200 + stretch_ns);
        end
        peer_pull = 1'b0;
    endtask : clocks
endmodule : itm_scl_peer

// [testbench/itm_transfer_mode_bench.sv]
// Self-checking bench for the transfer mode block
`timescale 1ns/1ps
module itm_transfer_mode_bench;
    import itm_pkg::*;
    logic           SYS_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [11:0]    PADDR;
    logic [31:0]    PWDATA, PRDATA;
    logic           SCL_OUT, SCL_OE, BIT_STROBE, scl_wire;
    itm_shift_cfg_t SHIFT_CFG;
    int             n_mismatch = 0;    // Failed comparisons
    int             total_checks = 0;  // All comparisons
    int             falls, strobes, waits, gap, base_gap;  // Frame observations
    //////////////////////////////////////////////////////////////////////////////
    itm_transfer_mode u_itm_transfer_mode (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_IN(scl_wire),
        .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SHIFT_CFG(SHIFT_CFG), .BIT_STROBE(BIT_STROBE));
    itm_scl_peer peer (.dev_pull(SCL_OE), .scl_wire(scl_wire));
    // 20 MHz clock
    initial
    begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end
    //////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %08h expected %08h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; data taken at the edge where ready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge SYS_CLK);
        PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= wr; PADDR <= a; PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        // Held until the edge that sees ready; only the watchdog ends a hang
        do @(posedge SYS_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0; PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r; logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r; logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask : rd_chk
    // Mode register image: order, wait, reserved ones, guard one, counter
    function automatic logic [31:0] mv(input logic o, input logic w, input logic [2:0] c);
        return {24'h0, o, w, 3'b111, c};
    endfunction : mv
    //////////////////////////////////////////////////////////////////////////////
    // Field access; master idle so a held-low wire counts no bits
    task automatic t_regs;
        logic [31:0] r; logic e;
        rd_chk(ITM_MODE_OFFSET, 32'h00000038);
        wr(ITM_CTRL_OFFSET, 32'h2);
        wr(ITM_MODE_OFFSET, 32'hFF);
        rd_chk(ITM_MODE_OFFSET, mv(1, 1, 0));
        check({31'h0, SHIFT_CFG.lsb_first}, 32'h1);
        wr(ITM_MODE_OFFSET, 32'h48);
        wr(ITM_CTRL_OFFSET, 32'h3);
        peer.peer_pull <= 1'b1;
        wr(ITM_MODE_OFFSET, 32'h45);
        rd_chk(ITM_MODE_OFFSET, mv(0, 1, 5));
        wr(ITM_MODE_OFFSET, 32'h4A);
        rd_chk(ITM_MODE_OFFSET, mv(0, 1, 5));
        wr(ITM_MODE_OFFSET, 32'h00);
        peer.peer_pull <= 1'b0;
        rd_chk(ITM_MODE_OFFSET, mv(0, 0, 0));
        check({31'h0, SHIFT_CFG.lsb_first}, 32'h0);
        apb(1'b0, 12'h00C, 32'h0, r, e);
        check({r[30:0], e}, 32'h1);
    endtask : t_regs
    // One frame; ext is the count of clocks the peer gives in slave mode
    task automatic frame(input logic [31:0] ctrl, input logic [31:0] mode, input int ext,
                         input int nbits);
        int i, low; logic prev;
        wr(ITM_MODE_OFFSET, mode);
        wr(ITM_CTRL_OFFSET, ctrl);
        falls = 0; strobes = 0; waits = 0; gap = 0; low = 0; prev = scl_wire;
        fork
            if (ext > 0) begin #37; peer.clocks(ext, ctrl[0] ? 0 : 100); end
        join_none
        wr(ITM_CTRL_OFFSET, ctrl | 32'h4);
        check({28'h0, SHIFT_CFG.bits_left}, 32'(nbits));
        for (i = 0; i < 600 && !(falls == nbits && scl_wire && low == 0); i++)
        begin
            @(negedge SYS_CLK);
            strobes += int'(BIT_STROBE);
            waits += int'(SHIFT_CFG.wait_req);
            if (!scl_wire) low++;
            if (prev && !scl_wire) falls++;
            if (!prev && scl_wire) begin if (falls == 9) gap = low; low = 0; end
            prev = scl_wire;
        end
        // The last bit completes after the final rise, so keep counting
        repeat (20)
        begin
            @(negedge SYS_CLK);
            strobes += int'(BIT_STROBE);
        end
        check(32'(strobes), 32'(nbits));
        check({28'h0, SHIFT_CFG.bits_left}, 32'h0);
        check({30'h0, SCL_OE, SCL_OUT}, 32'h0);
    endtask : frame
    //////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    // Watchdog well beyond the expected run
    initial
    begin
        #(50 * 20000);
        n_mismatch++;
        final_report();
    end
    initial
    begin
        RST = 1'b1; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0;
        PADDR = 12'h000; PWDATA = 32'h0;
        repeat (8) @(posedge SYS_CLK);
        RST <= 1'b0;
        t_regs();
        frame(32'h3, mv(0, 0, 0), 0, 9);
        base_gap = gap;
        check(32'(base_gap), 32'(ITM_HALF_CYCLES));
        rd_chk(ITM_MODE_OFFSET, mv(0, 0, 0));
        frame(32'h3, mv(0, 1, 0), 0, 9);
        check(32'(gap - base_gap), 32'h10);
        check(32'(waits), 32'h10);
        frame(32'h1, mv(0, 1, 0), 9, 9);
        check(32'(waits), 32'h0);
        frame(32'h2, mv(0, 1, 0), 0, 8);
        check(32'(waits), 32'h0);
        frame(32'h0, mv(1, 1, 0), 8, 8);
        check(32'(waits), 32'h0);
        rd_chk(ITM_MODE_OFFSET, mv(1, 1, 0));
        final_report();
    end
endmodule : itm_transfer_mode_bench
